// ---- logic/csoc_ctrl.sv ----
// Sense amplifier control and overcurrent protection, top level
`timescale 1ns/1ps
`default_nettype none

module csoc_ctrl (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic bidir_select,
  input wire logic amp_disable,
  input wire logic [1:0] amp_gain_sel,
  input wire logic shunt_placement_hint,
  input wire logic output_load_cap_range,
  input wire logic [1:0] trip_level_sel,
  input wire logic overcurrent_trip_enable,
  input wire logic [1:0] overcurrent_filter_sel,
  input wire logic supply_undervoltage,
  input wire logic supply_overvoltage,
  input wire logic charge_pump_undervoltage,
  input wire logic over_temperature,
  input wire logic general_status_clear,
  input wire logic [9:0] sense_level,
  output logic amp_enable,
  output logic amp_output_force_low,
  output logic amp_bidir_mode,
  output logic amp_ref_mid,
  output logic [6:0] amp_gain,
  output logic amp_high_side_mode,
  output logic amp_cap_high,
  output logic overcurrent_flag,
  output logic overcurrent_ch_flag,
  output logic global_error_flag,
  output logic gates_off_static
);

  csoc_filt_if fif ();

  csoc_pkg::csoc_state_t state;
  csoc_pkg::csoc_state_t next_state;

  logic amp_fault;
  logic amp_active;
  logic [6:0] gain_lut;
  logic [csoc_pkg::LVL_W-1:0] uni_thr;
  logic [2:0] win_mult;
  logic [csoc_pkg::LVL_W-1:0] win_off;
  logic [csoc_pkg::LVL_W-1:0] win_hi;
  logic [csoc_pkg::LVL_W-1:0] win_lo;
  logic over_uni;
  logic over_bi;
  logic flag_next;

  // Amplifier shut off on any supply or thermal fault
  assign amp_fault = supply_undervoltage | supply_overvoltage |
                     charge_pump_undervoltage | over_temperature;
  assign amp_active = !(amp_fault | amp_disable);

  assign gain_lut = (amp_gain_sel == 2'h0) ? csoc_pkg::GAIN_10 :
                    (amp_gain_sel == 2'h1) ? csoc_pkg::GAIN_20 :
                    (amp_gain_sel == 2'h2) ? csoc_pkg::GAIN_40 :
                    csoc_pkg::GAIN_80;

  // Unidirectional: one upper threshold at or above mid-scale
  assign uni_thr = csoc_pkg::LVL_MID +
                   csoc_pkg::LVL_TENTH * {8'h00, trip_level_sel};
  assign over_uni = sense_level > uni_thr;

  // Bidirectional: symmetric window around mid-scale
  assign win_mult = (trip_level_sel == 2'h0) ? csoc_pkg::WIN_MULT0 :
                    (trip_level_sel == 2'h1) ? csoc_pkg::WIN_MULT1 :
                    (trip_level_sel == 2'h2) ? csoc_pkg::WIN_MULT2 :
                    csoc_pkg::WIN_MULT3;
  assign win_off = csoc_pkg::LVL_TWENTIETH * {7'h00, win_mult};
  assign win_hi = csoc_pkg::LVL_MID + win_off;
  assign win_lo = csoc_pkg::LVL_MID - win_off;
  assign over_bi = (sense_level > win_hi) ||
                   (sense_level < win_lo);

  // A silenced amplifier reads low, which must not look like a
  // negative overcurrent in bidirectional mode
  assign fif.comp_raw = amp_active &&
                        (bidir_select ? over_bi : over_uni);
  assign fif.filt_sel = overcurrent_filter_sel;

  csoc_oc_filter u_filter (
    .core_clk(core_clk),
    .reset(reset),
    .fif(fif)
  );

  // Protection state; a detect always wins over any clear
  always_comb begin
    next_state = state;
    unique case (state)
      csoc_pkg::ST_CLEAR: begin
        if (fif.detect) begin
          next_state = overcurrent_trip_enable ? csoc_pkg::ST_TRIPPED :
                       csoc_pkg::ST_FLAGGED;
        end
      end
      csoc_pkg::ST_FLAGGED: begin
        if (fif.detect) begin
          if (overcurrent_trip_enable) begin
            next_state = csoc_pkg::ST_TRIPPED;
          end
        end else if (!overcurrent_trip_enable && fif.absent_long) begin
          next_state = csoc_pkg::ST_CLEAR;
        end else if (general_status_clear && !fif.present) begin
          next_state = csoc_pkg::ST_CLEAR;
        end
      end
      csoc_pkg::ST_TRIPPED: begin
        if (!overcurrent_trip_enable) begin
          next_state = csoc_pkg::ST_FLAGGED;
        end else if (fif.detect) begin
          next_state = csoc_pkg::ST_TRIPPED;
        end else if (general_status_clear) begin
          // Gates released on clear; flags stay while current persists
          next_state = fif.present ? csoc_pkg::ST_FLAGGED :
                       csoc_pkg::ST_CLEAR;
        end
      end
      default: next_state = csoc_pkg::ST_CLEAR;
    endcase
  end

  assign flag_next = (next_state != csoc_pkg::ST_CLEAR);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= csoc_pkg::ST_CLEAR;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      overcurrent_flag <= 1'b0;
      overcurrent_ch_flag <= 1'b0;
      global_error_flag <= 1'b0;
      gates_off_static <= 1'b0;
    end else begin
      overcurrent_flag <= flag_next;
      overcurrent_ch_flag <= flag_next;
      global_error_flag <= flag_next;
      gates_off_static <= (next_state == csoc_pkg::ST_TRIPPED);
    end
  end

  // Amplifier configuration is retimed so every output is a flop
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      amp_enable <= 1'b0;
      amp_output_force_low <= 1'b1;
      amp_bidir_mode <= 1'b0;
      amp_ref_mid <= 1'b0;
      amp_gain <= csoc_pkg::GAIN_RESET;
      amp_high_side_mode <= 1'b0;
      amp_cap_high <= 1'b0;
    end else begin
      amp_enable <= amp_active;
      amp_output_force_low <= !amp_active;
      amp_bidir_mode <= bidir_select;
      amp_ref_mid <= bidir_select;
      amp_gain <= gain_lut;
      amp_high_side_mode <= shunt_placement_hint;
      amp_cap_high <= output_load_cap_range;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_detect_report;
    !overcurrent_trip_enable && fif.detect;
  endsequence

  sequence s_shut_detect;
    overcurrent_trip_enable && fif.detect;
  endsequence

  a_mode_follows: assert property (
    ##1 amp_bidir_mode == $past(bidir_select) &&
        amp_ref_mid == $past(bidir_select)
  ) else $error("direction mode not applied");

  a_amp_silenced: assert property (
    (amp_fault || amp_disable) |=> amp_output_force_low && !amp_enable
  ) else $error("amplifier active during fault or disable");

  a_gain_top: assert property (
    amp_gain_sel == 2'h3 ##1 amp_gain_sel == 2'h1 |->
      amp_gain == csoc_pkg::GAIN_80 ##1 amp_gain == csoc_pkg::GAIN_20
  ) else $error("gain code mismatch");

  a_uni_edge: assert property (
    amp_active && !bidir_select && trip_level_sel == 2'h1 |->
      (sense_level == 10'd600 ? !fif.comp_raw : 1'b1) &&
      (sense_level == 10'd601 ? fif.comp_raw : 1'b1)
  ) else $error("unidirectional threshold wrong");

  a_bidir_window: assert property (
    amp_active && bidir_select && trip_level_sel == 2'h2 |->
      (sense_level == 10'd249 ? fif.comp_raw : 1'b1) &&
      (sense_level == 10'd750 ? !fif.comp_raw : 1'b1) &&
      (sense_level == 10'd751 ? fif.comp_raw : 1'b1)
  ) else $error("bidirectional window wrong");

  a_report_keeps_gates: assert property (
    s_detect_report and state == csoc_pkg::ST_CLEAR |=>
      overcurrent_flag && global_error_flag && !gates_off_static
  ) else $error("report mode touched the gates");

  a_report_autoclear: assert property (
    state == csoc_pkg::ST_FLAGGED && !overcurrent_trip_enable &&
    fif.absent_long && !fif.detect |=> !overcurrent_flag
  ) else $error("report flag not cleared after absence");

  a_shutdown_trip: assert property (
    s_shut_detect |=> gates_off_static && overcurrent_flag ##1
      gates_off_static || !$past(overcurrent_trip_enable) ||
      $past(general_status_clear)
  ) else $error("shutdown not applied on overcurrent");

  a_enable_release: assert property (
    gates_off_static && !overcurrent_trip_enable |=> !gates_off_static
  ) else $error("gates not released when trip enable reset");

  a_clear_needs_absence: assert property (
    overcurrent_flag && fif.present && general_status_clear |=>
      overcurrent_flag
  ) else $error("flag cleared while condition present");

  a_clear_releases: assert property (
    state == csoc_pkg::ST_TRIPPED && general_status_clear &&
    !fif.detect |=> !gates_off_static
  ) else $error("status clear did not release gates");

  a_flags_agree: assert property (
    overcurrent_flag == overcurrent_ch_flag &&
    overcurrent_flag == global_error_flag
  ) else $error("status copies disagree");

  a_bidir_applied: assert property (
    bidir_select |=> amp_bidir_mode && amp_ref_mid
  ) else $error("bidirectional mode not applied");

  a_uni_applied: assert property (
    !bidir_select |=> !amp_bidir_mode && !amp_ref_mid
  ) else $error("unidirectional mode not applied");

  a_amp_running: assert property (
    !(amp_fault || amp_disable) |=> amp_enable && !amp_output_force_low
  ) else $error("amplifier not running");

  a_silent_no_trip: assert property (
    !amp_active |-> !fif.comp_raw
  ) else $error("silenced amplifier raised the comparator");

  a_gain_code0: assert property (
    amp_gain_sel == 2'h0 |=> amp_gain == csoc_pkg::GAIN_10
  ) else $error("gain code 0 mismatch");

  a_gain_code1: assert property (
    amp_gain_sel == 2'h1 |=> amp_gain == csoc_pkg::GAIN_20
  ) else $error("gain code 1 mismatch");

  a_gain_code2: assert property (
    amp_gain_sel == 2'h2 |=> amp_gain == csoc_pkg::GAIN_40
  ) else $error("gain code 2 mismatch");

  a_uni_low_code: assert property (
    amp_active && !bidir_select && trip_level_sel == 2'h0 &&
    sense_level == 10'h1f5 |-> fif.comp_raw
  ) else $error("lowest unidirectional threshold wrong");

  a_bidir_narrow: assert property (
    amp_active && bidir_select && trip_level_sel == 2'h0 &&
    sense_level == 10'h190 |-> !fif.comp_raw
  ) else $error("narrow bidirectional window wrong");

  a_report_no_gates: assert property (
    !overcurrent_trip_enable |=> !gates_off_static
  ) else $error("report mode switched gates off");

  a_trip_holds: assert property (
    gates_off_static && overcurrent_trip_enable &&
    !general_status_clear |=> gates_off_static
  ) else $error("gates released without clear");

  a_shut_flag_sticky: assert property (
    overcurrent_flag && overcurrent_trip_enable &&
    !general_status_clear |=> overcurrent_flag
  ) else $error("shutdown flag cleared without clear");

  a_clear_to_idle: assert property (
    state == csoc_pkg::ST_FLAGGED && overcurrent_trip_enable &&
    general_status_clear && !fif.present && !fif.detect |=>
      !overcurrent_flag
  ) else $error("clear did not reset absent overcurrent");

endmodule : csoc_ctrl

`default_nettype wire

// ---- logic/csoc_filt_if.sv ----
// Link between the protection control and the overcurrent filter
`timescale 1ns/1ps
`default_nettype none

interface csoc_filt_if;
  logic comp_raw;
  logic [1:0] filt_sel;
  logic detect;
  logic present;
  logic absent_long;

  modport filt (
    input comp_raw,
    input filt_sel,
    output detect,
    output present,
    output absent_long
  );

  modport ctrl (
    output comp_raw,
    output filt_sel,
    input detect,
    input present,
    input absent_long
  );
endinterface : csoc_filt_if

`default_nettype wire

// ---- logic/csoc_oc_filter.sv ----
// Overcurrent comparator synchroniser and persistence filter
`timescale 1ns/1ps
`default_nettype none

module csoc_oc_filter (
  input wire logic core_clk,
  input wire logic reset,
  csoc_filt_if.filt fif
);

  logic sync_a;
  logic sync_b;
  logic [csoc_pkg::CNT_W-1:0] hi_cnt;
  logic [csoc_pkg::CNT_W-1:0] lo_cnt;
  logic [csoc_pkg::CNT_W-1:0] next_hi_cnt;
  logic [csoc_pkg::CNT_W-1:0] next_lo_cnt;
  logic [csoc_pkg::CNT_W-1:0] limit;

  // Time is counted on the comparator result only
  assign limit = (fif.filt_sel == 2'h0) ? csoc_pkg::FILT_CYC0 :
                 (fif.filt_sel == 2'h1) ? csoc_pkg::FILT_CYC1 :
                 (fif.filt_sel == 2'h2) ? csoc_pkg::FILT_CYC2 :
                 csoc_pkg::FILT_CYC3;

  // Saturating counters; >= and > keep them sane when the select shrinks
  assign next_hi_cnt = !sync_b ? '0 :
                       (hi_cnt >= limit) ? hi_cnt :
                       hi_cnt + 11'h001;
  assign next_lo_cnt = sync_b ? '0 :
                       (lo_cnt > limit) ? lo_cnt :
                       lo_cnt + 11'h001;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= fif.comp_raw;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
    end else begin
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
    end
  end

  assign fif.detect = (hi_cnt >= limit);
  assign fif.present = sync_b;
  assign fif.absent_long = (lo_cnt > limit);

  a_detect_persist: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(fif.detect) && $stable(fif.filt_sel) |->
      $past(hi_cnt) == limit - 11'h001 && $past(sync_b)
  ) else $error("overcurrent detected before filter time");

  a_detect_drops: assert property (
    @(posedge core_clk) disable iff (reset)
    !sync_b && fif.filt_sel == 2'h0 |=> !fif.detect
  ) else $error("detect held after comparator fell");

  a_absent_long_gap: assert property (
    @(posedge core_clk) disable iff (reset)
    $rose(fif.absent_long) && $stable(fif.filt_sel) |->
      $past(lo_cnt) == limit
  ) else $error("absence declared too early");

endmodule : csoc_oc_filter

`default_nettype wire

// ---- logic/csoc_pkg.sv ----
// Constants and types of the current sense overcurrent control block
// How it works
// - Direction bit 1 selects bidirectional sensing
// - Direction bit 0 selects unidirectional sensing
// - Supply, temperature faults or disable silence amplifier
// - Gain codes select 10, 20, 40, 80
// - Unidirectional trip above mid plus tenths
// - Bidirectional symmetric window of twentieths trips
// - Report mode sets flags, gates untouched
// - Report mode flags self-clear after filter time
// - Shutdown mode sets flags, switches gates off
// - Status clear or enable reset releases gates
// - Shutdown mode flags need clear and absence
// - Filter time selectable, measured at comparator
`default_nettype none

package csoc_pkg;

  localparam int LVL_W = 10;
  localparam int CNT_W = 11;
  localparam int CLK_PERIOD_NS = 4;

  // Sense output level in thousandths of the logic supply
  localparam logic [LVL_W-1:0] LVL_FULL = 10'd1000;
  localparam logic [LVL_W-1:0] LVL_MID = 10'd500;
  localparam logic [LVL_W-1:0] LVL_TENTH = 10'd100;
  localparam logic [LVL_W-1:0] LVL_TWENTIETH = 10'd50;

  // Bidirectional window half-widths in twentieths
  localparam logic [2:0] WIN_MULT0 = 3'h2;
  localparam logic [2:0] WIN_MULT1 = 3'h4;
  localparam logic [2:0] WIN_MULT2 = 3'h5;
  localparam logic [2:0] WIN_MULT3 = 3'h6;

  localparam logic [6:0] GAIN_10 = 7'd10;
  localparam logic [6:0] GAIN_20 = 7'd20;
  localparam logic [6:0] GAIN_40 = 7'd40;
  localparam logic [6:0] GAIN_80 = 7'd80;
  localparam logic [6:0] GAIN_RESET = GAIN_10;

  // Overcurrent filter times per select code
  localparam int FILT_NS0 = 500;
  localparam int FILT_NS1 = 1000;
  localparam int FILT_NS2 = 2000;
  localparam int FILT_NS3 = 4000;
  localparam logic [CNT_W-1:0] FILT_CYC0 =
    CNT_W'((FILT_NS0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FILT_CYC1 =
    CNT_W'((FILT_NS1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FILT_CYC2 =
    CNT_W'((FILT_NS2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FILT_CYC3 =
    CNT_W'((FILT_NS3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_CLEAR = 3'b001,
    ST_FLAGGED = 3'b010,
    ST_TRIPPED = 3'b100
  } csoc_state_t;

endpackage : csoc_pkg

`default_nettype wire

// ---- testbench/csoc_mcu_model.sv ----
// Controller model that configures the block and clears its status
`timescale 1ns/1ps
`default_nettype none

module csoc_mcu_model (
  input wire logic core_clk,
  output var logic bidir_select,
  output var logic amp_disable,
  output var logic [1:0] amp_gain_sel,
  output var logic shunt_placement_hint,
  output var logic output_load_cap_range,
  output var logic [1:0] trip_level_sel,
  output var logic overcurrent_trip_enable,
  output var logic [1:0] overcurrent_filter_sel,
  output var logic general_status_clear
);
  initial begin
    {bidir_select, amp_disable, amp_gain_sel} = 4'h0;
    {shunt_placement_hint, output_load_cap_range} = 2'h0;
    {trip_level_sel, overcurrent_trip_enable} = 3'h0;
    {overcurrent_filter_sel, general_status_clear} = 3'h0;
  end

  // Writes land just after an edge, as a serial write would
  task automatic set_cfg(input logic bid, input logic dis,
                         input logic [1:0] gain, input logic high_side,
                         input logic cap_big, input logic [1:0] trip,
                         input logic en, input logic [1:0] filt);
    @(posedge core_clk);
    #1;
    bidir_select = bid;
    amp_disable = dis;
    amp_gain_sel = gain;
    shunt_placement_hint = high_side;
    output_load_cap_range = cap_big;
    trip_level_sel = trip;
    overcurrent_trip_enable = en;
    overcurrent_filter_sel = filt;
  endtask : set_cfg

  // One-cycle clear pulse
  task automatic clear_status();
    @(posedge core_clk);
    #1;
    general_status_clear = 1'b1;
    @(posedge core_clk);
    #1;
    general_status_clear = 1'b0;
  endtask : clear_status
endmodule : csoc_mcu_model

`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the sense amplifier overcurrent control
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic core_clk, reset, bidir_select, amp_disable, shunt_placement_hint;
  logic output_load_cap_range, overcurrent_trip_enable, general_status_clear;
  logic [1:0] amp_gain_sel, trip_level_sel, overcurrent_filter_sel;
  logic [3:0] flt;
  logic [9:0] sense_level;
  logic amp_enable, amp_output_force_low, amp_bidir_mode, amp_ref_mid;
  logic amp_high_side_mode, amp_cap_high, overcurrent_flag, gates_off_static;
  logic overcurrent_ch_flag, global_error_flag;
  logic [6:0] amp_gain;
  logic [15:0] lfsr;
  int fail_count, comparisons, n, nf;

  csoc_mcu_model mcu (.core_clk, .bidir_select, .amp_disable, .amp_gain_sel,
    .shunt_placement_hint, .output_load_cap_range, .trip_level_sel,
    .overcurrent_trip_enable, .overcurrent_filter_sel, .general_status_clear);

  csoc_ctrl dut (.core_clk, .reset, .bidir_select, .amp_disable,
    .amp_gain_sel, .shunt_placement_hint, .output_load_cap_range,
    .trip_level_sel, .overcurrent_trip_enable, .overcurrent_filter_sel,
    .supply_undervoltage(flt[0]), .supply_overvoltage(flt[1]),
    .charge_pump_undervoltage(flt[2]), .over_temperature(flt[3]),
    .general_status_clear, .sense_level, .amp_enable, .amp_output_force_low,
    .amp_bidir_mode, .amp_ref_mid, .amp_gain, .amp_high_side_mode,
    .amp_cap_high, .overcurrent_flag, .overcurrent_ch_flag,
    .global_error_flag, .gates_off_static);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [15:0] next_lfsr(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction : next_lfsr

  function automatic int filt_n(input logic [1:0] s);
    case (s)
      2'h0: return int'(csoc_pkg::FILT_CYC0);
      2'h1: return int'(csoc_pkg::FILT_CYC1);
      2'h2: return int'(csoc_pkg::FILT_CYC2);
      default: return int'(csoc_pkg::FILT_CYC3);
    endcase
  endfunction : filt_n

  function automatic int win(input logic [1:0] c);
    return (c == 2'h0) ? 2 : (c == 2'h1) ? 4 : (c == 2'h2) ? 5 : 6;
  endfunction : win

  function automatic logic exp_trip(input logic bid, input logic [1:0] c,
                                    input int lvl);
    if (!bid)
      return lvl > 500 + 100 * c;
    return (lvl > 500 + 50 * win(c)) || (lvl < 500 - 50 * win(c));
  endfunction : exp_trip

  task automatic test_done();
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      fail_count++;
      $display("ERROR t=%0t cycles got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick

  // Counts edges until the flag reaches the wanted level
  task automatic wait_flag(input logic want, input int lim, output int k);
    k = 0;
    while (overcurrent_flag !== want && k < lim) begin
      tick(1);
      k++;
    end
    if (overcurrent_flag !== want) begin
      fail_count++;
      $display("ERROR t=%0t wait got=%h exp=%h", $time, overcurrent_flag,
               want);
      test_done();
    end
  endtask : wait_flag

  // Report mode: apply a level, expect trip or not, then return to idle
  task automatic trip_case(input int lvl, input logic exp);
    int k, kf;
    k = filt_n(overcurrent_filter_sel);
    sense_level = lvl[9:0];
    if (exp) begin
      wait_flag(1'b1, k + 40, kf);
      chk_cnt(kf, k + 3);
      chk({overcurrent_ch_flag, global_error_flag, gates_off_static},
          16'h0006);
      sense_level = 10'h1f4;
      wait_flag(1'b0, 2 * k + 40, kf);
      chk(kf > k, 16'h0001);
    end else begin
      tick(k + 10);
      chk(overcurrent_flag, 16'h0000);
      sense_level = 10'h1f4;
      tick(4);
    end
  endtask : trip_case

  initial begin
    reset = 1'b1;
    flt = 4'h0;
    sense_level = 10'h000;
    fail_count = 0;
    comparisons = 0;
    lfsr = 16'h687e;
    repeat (8) @(posedge core_clk);
    #1;
    chk({amp_gain, amp_output_force_low, overcurrent_flag, gates_off_static,
         amp_enable}, 16'h00a8);
    reset = 1'b0;
    // Every gain code, direction, disable, shunt and cap bits at random
    for (int g = 0; g < 4; g++) begin
      lfsr = next_lfsr(lfsr);
      mcu.set_cfg(lfsr[0], lfsr[1], g[1:0], lfsr[4], lfsr[5], 2'h0, 1'b0,
                  2'h0);
      tick(2);
      chk({amp_enable, amp_output_force_low, amp_bidir_mode, amp_ref_mid,
           amp_high_side_mode, amp_cap_high, amp_gain},
          {3'h0, ~lfsr[1], lfsr[1], lfsr[0], lfsr[0], lfsr[4], lfsr[5],
           7'h0a << g});
    end
    // Gain code 3 straight to 1 exercises the gain step check
    mcu.set_cfg(1'b0, 1'b0, 2'h1, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0);
    for (int i = 0; i < 4; i++) begin
      flt = 4'h1 << i;
      tick(2);
      chk({amp_enable, amp_output_force_low}, 16'h0001);
    end
    flt = 4'h0;
    tick(2);
    // Exact filter duration for every filter code
    for (int s = 0; s < 4; s++) begin
      mcu.set_cfg(1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 1'b0, s[1:0]);
      trip_case(900, 1'b1);
    end
    mcu.set_cfg(1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0);
    n = filt_n(2'h0);
    sense_level = 10'h384;
    tick(n - 1);
    sense_level = 10'h000;
    tick(n + 10);
    chk(overcurrent_flag, 16'h0000);
    // Threshold boundaries in both modes
    for (int c = 0; c < 4; c++) begin
      mcu.set_cfg(1'b0, 1'b0, 2'h0, 1'b0, 1'b0, c[1:0], 1'b0, 2'h0);
      trip_case(500 + 100 * c, 1'b0);
      trip_case(501 + 100 * c, 1'b1);
      mcu.set_cfg(1'b1, 1'b0, 2'h0, 1'b0, 1'b0, c[1:0], 1'b0, 2'h0);
      trip_case(500 + 50 * win(c), 1'b0);
      trip_case(501 + 50 * win(c), 1'b1);
      trip_case(500 - 50 * win(c), 1'b0);
      trip_case(499 - 50 * win(c), 1'b1);
    end
    for (int r = 0; r < 6; r++) begin
      lfsr = next_lfsr(lfsr);
      mcu.set_cfg(lfsr[0], 1'b0, 2'h0, 1'b0, 1'b0, lfsr[2:1], 1'b0, 2'h0);
      trip_case(int'(lfsr[15:6]) % 1001,
                exp_trip(lfsr[0], lfsr[2:1], int'(lfsr[15:6]) % 1001));
    end
    // Shutdown mode: latch, release by clear, then by enable reset
    mcu.set_cfg(1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 1'b1, 2'h0);
    sense_level = 10'h384;
    wait_flag(1'b1, n + 40, nf);
    chk({overcurrent_ch_flag, global_error_flag, gates_off_static},
        16'h0007);
    // Detect must drop first, else the trip wins over the clear
    sense_level = 10'h000;
    tick(3);
    sense_level = 10'h384;
    tick(1);
    mcu.clear_status();
    tick(1);
    chk({overcurrent_flag, gates_off_static}, 16'h0002);
    sense_level = 10'h000;
    tick(n + 10);
    chk(overcurrent_flag, 16'h0001);
    mcu.clear_status();
    chk({overcurrent_flag, overcurrent_ch_flag, global_error_flag,
         gates_off_static}, 16'h0000);
    sense_level = 10'h384;
    wait_flag(1'b1, n + 40, nf);
    mcu.set_cfg(1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0);
    tick(1);
    chk(gates_off_static, 16'h0000);
    sense_level = 10'h000;
    wait_flag(1'b0, 2 * n + 40, nf);
    chk(nf > n, 16'h0001);
    test_done();
  end
endmodule : tb

`default_nettype wire
